//--- design/flag_bank.sv
// Purpose: bank of sticky event flags that software may overwrite
// Assumes: set and write come from the clock domain of clock
// Notes: a hardware set wins over a software clear in the same cycle
`timescale 1ns/1ps
`default_nettype none
module flag_bank #(
	parameter int WIDTH = 12
) (
	// clock and reset
	input wire logic clock,
	input wire logic sys_rst,
	// events and software write
	input wire logic [WIDTH-1:0] set_evt,
	input wire logic wr_en,
	input wire logic [WIDTH-1:0] wr_data,
	// flags
	output logic [WIDTH-1:0] flags_q
);
	genvar i;
	generate
		for (i = 0; i < WIDTH; i++) begin : g_flag
			logic flag_d;
			always_comb begin
				flag_d = set_evt[i] | (wr_en ? wr_data[i] : flags_q[i]);
			end
			always_ff @(posedge clock or posedge sys_rst) begin
				if (sys_rst) begin
					flags_q[i] <= 1'b0;
				end else begin
					flags_q[i] <= flag_d;
				end
			end
		end
	endgenerate
endmodule : flag_bank
`default_nettype wire

//--- design/mcu_interrupt_control.sv
// Purpose: interrupt collection, masking and core redirection
// Assumes: core gives a one-cycle pulse on return, a sleep level
// Notes: registers reached over APB, zero wait, one setup cycle
// ****************************************
// ****************************************
//
// The implementer's own choices: the address map and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module mcu_interrupt_control
	import irq_ctrl_pkg::*;
(
	// clock and reset
	input wire logic clock,
	input wire logic sys_rst,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// event sources
	input wire logic ext_irq_pin,
	input wire logic pin_change_irq,
	input wire logic timer0_overflow,
	input wire logic [N_PERIPH-1:0] periph_event,
	// core side
	input wire logic return_from_isr,
	input wire logic sleep_active,
	output logic irq_request,
	output logic vector_load,
	output logic push_return,
	output logic [12:0] vector_addr,
	output logic wake_up
);
	// ****************************************
	// apb slave
	// ****************************************
	logic setup_phase, wr_strobe, addr_hit;
	logic [31:0] rdata_d, prdata_q;
	logic pready_d, pready_q, pslverr_d, pslverr_q;
	logic wr_ctrl, wr_preq, wr_pen, wr_option, wr_analog;

	logic [7:0] ctrl_view;
	logic [N_PERIPH-1:0] preq_q, pen_q, pen_d;
	logic glb_en_q, glb_en_d, grp_en_q, grp_en_d;
	logic [2:0] src_en_q, src_en_d;
	logic [2:0] core_flags_q;
	logic polarity_q, polarity_d, analog_q, analog_d;
	logic pin_level, ext_edge;
	logic pending_any, counting;
	logic wake_arm_q, wake_arm_d, sleep_prev_q;

	assign setup_phase = psel & ~penable;
	assign wr_strobe = psel & penable & pready_q & pwrite;
	assign addr_hit = (paddr[7:0] == OFS_CTRL) || (paddr[7:0] == OFS_PREQ) ||
		(paddr[7:0] == OFS_PEN) || (paddr[7:0] == OFS_OPTION) ||
		(paddr[7:0] == OFS_ANALOG) || (paddr[7:0] == OFS_STATUS);
	assign wr_ctrl = wr_strobe && (paddr[7:0] == OFS_CTRL) && (paddr[31:8] == 24'h000000);
	assign wr_preq = wr_strobe && (paddr[7:0] == OFS_PREQ) && (paddr[31:8] == 24'h000000);
	assign wr_pen = wr_strobe && (paddr[7:0] == OFS_PEN) && (paddr[31:8] == 24'h000000);
	assign wr_option = wr_strobe && (paddr[7:0] == OFS_OPTION) && (paddr[31:8] == 24'h000000);
	assign wr_analog = wr_strobe && (paddr[7:0] == OFS_ANALOG) && (paddr[31:8] == 24'h000000);

	assign ctrl_view = {glb_en_q, grp_en_q, src_en_q, core_flags_q};

	always_comb begin
		rdata_d = prdata_q;
		pready_d = 1'b0;
		pslverr_d = 1'b0;
		if (setup_phase) begin
			pready_d = 1'b1;
			pslverr_d = ~addr_hit || (paddr[31:8] != 24'h000000);
			rdata_d = 32'h00000000;
			case (paddr[7:0])
				OFS_CTRL: rdata_d = {24'h000000, ctrl_view};
				OFS_PREQ: rdata_d = {20'h00000, preq_q};
				OFS_PEN: rdata_d = {20'h00000, pen_q};
				OFS_OPTION: rdata_d = {31'h00000000, polarity_q};
				OFS_ANALOG: rdata_d = {31'h00000000, analog_q};
				OFS_STATUS: rdata_d = {28'h0000000, wake_arm_q, pin_level, counting,
					pending_any};
				default: rdata_d = 32'h00000000;
			endcase
		end
	end

	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			prdata_q <= 32'h00000000;
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
		end else begin
			prdata_q <= rdata_d;
			pready_q <= pready_d;
			pslverr_q <= pslverr_d;
		end
	end

	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;

	// ****************************************
	// sources and flags
	// ****************************************
	pin_edge_detect u_pin (
		.clock(clock),
		.sys_rst(sys_rst),
		.pin_raw(ext_irq_pin),
		.polarity(polarity_q),
		.analog_sel(analog_q),
		.pin_level(pin_level),
		.edge_seen(ext_edge)
	);

	// core flags: timer0, ext edge, pin change in control bits 2..0
	flag_bank #(.WIDTH(3)) u_core_flags (
		.clock(clock),
		.sys_rst(sys_rst),
		.set_evt({timer0_overflow, ext_edge, pin_change_irq}),
		.wr_en(wr_ctrl),
		.wr_data(pwdata[BIT_T0_FLAG:BIT_PCH_FLAG]),
		.flags_q(core_flags_q)
	);

	flag_bank #(.WIDTH(N_PERIPH)) u_periph_flags (
		.clock(clock),
		.sys_rst(sys_rst),
		.set_evt(periph_event),
		.wr_en(wr_preq),
		.wr_data(pwdata[N_PERIPH-1:0]),
		.flags_q(preq_q)
	);

	// ****************************************
	// enables and configuration
	// ****************************************
	logic take_fire;

	always_comb begin
		glb_en_d = glb_en_q;
		grp_en_d = grp_en_q;
		src_en_d = src_en_q;
		pen_d = wr_pen ? pwdata[N_PERIPH-1:0] : pen_q;
		polarity_d = wr_option ? pwdata[BIT_POLARITY] : polarity_q;
		analog_d = wr_analog ? pwdata[BIT_EXT_ANALOG] : analog_q;
		if (wr_ctrl) begin
			glb_en_d = pwdata[BIT_GLB_EN];
			grp_en_d = pwdata[BIT_GRP_EN];
			src_en_d = pwdata[BIT_T0_EN:BIT_PCH_EN];
		end
		if (take_fire) begin
			glb_en_d = 1'b0;
		end
		if (return_from_isr) begin
			glb_en_d = 1'b1;
		end
	end

	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			glb_en_q <= CTRL_RESET[BIT_GLB_EN];
			grp_en_q <= CTRL_RESET[BIT_GRP_EN];
			src_en_q <= CTRL_RESET[BIT_T0_EN:BIT_PCH_EN];
			pen_q <= PERIPH_RESET;
			polarity_q <= OPTION_RESET;
			analog_q <= ANALOG_RESET;
		end else begin
			glb_en_q <= glb_en_d;
			grp_en_q <= grp_en_d;
			src_en_q <= src_en_d;
			pen_q <= pen_d;
			polarity_q <= polarity_d;
			analog_q <= analog_d;
		end
	end

	// group enable gates all peripheral sources
	assign pending_any = (|(core_flags_q & src_en_q)) | (grp_en_q & (|(preq_q & pen_q)));
	assign irq_request = glb_en_q & pending_any;

	// ****************************************
	// take sequence, phase aligned
	// ****************************************
	take_state_e state_q, state_d;
	logic [1:0] phase_q, phase_d, icyc_q, icyc_d;
	logic vector_q, vector_d;
	logic is_q1;

	assign is_q1 = (phase_q == Q1_PHASE);
	assign counting = (state_q == ST_COUNT);

	always_comb begin
		phase_d = phase_q + 2'h1;
		state_d = state_q;
		icyc_d = icyc_q;
		take_fire = 1'b0;
		case (state_q)
			ST_IDLE: begin
				// flags are looked at only at q1
				if (is_q1 && irq_request) begin
					state_d = ST_COUNT;
					icyc_d = 2'h1;
				end
			end
			ST_COUNT: begin
				if (!irq_request) begin
					// cleared enable drops the take, flag left pending
					state_d = ST_IDLE;
				end else if (is_q1) begin
					if (icyc_q == LATENCY_INSTR) begin
						take_fire = 1'b1;
						state_d = ST_IDLE;
					end else begin
						icyc_d = icyc_q + 2'h1;
					end
				end
			end
			default: state_d = ST_IDLE;
		endcase
		vector_d = take_fire;
	end

	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			state_q <= ST_IDLE;
			phase_q <= Q4_PHASE;
			icyc_q <= 2'h0;
			vector_q <= 1'b0;
		end else begin
			state_q <= state_d;
			phase_q <= phase_d;
			icyc_q <= icyc_d;
			vector_q <= vector_d;
		end
	end

	assign vector_load = vector_q;
	assign push_return = vector_q;
	assign vector_addr = VECTOR_ADDR;

	// ****************************************
	// wake from sleep
	// ****************************************
	always_comb begin
		wake_arm_d = wake_arm_q;
		// enable state caught at sleep entry only
		if (sleep_active && !sleep_prev_q) begin
			wake_arm_d = src_en_q[BIT_EXT_EN - BIT_PCH_EN];
		end
	end

	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			wake_arm_q <= 1'b0;
			sleep_prev_q <= 1'b0;
		end else begin
			wake_arm_q <= wake_arm_d;
			sleep_prev_q <= sleep_active;
		end
	end

	assign wake_up = sleep_active & sleep_prev_q & wake_arm_q & core_flags_q[BIT_EXT_FLAG];

	// ****************************************
	// checks
	// ****************************************
	logic [4:0] wait_clks_q;
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			wait_clks_q <= 5'h00;
		end else begin
			wait_clks_q <= counting ? wait_clks_q + 5'h01 : 5'h00;
		end
	end

	a_take_needs_en: assert property (@(posedge clock) disable iff (sys_rst)
		vector_load |-> $past(glb_en_q) && $past(pending_any))
		else $error("vector taken without enable and pending source");
	a_take_clears_en: assert property (@(posedge clock) disable iff (sys_rst)
		$rose(vector_load) && !$past(return_from_isr) |-> !glb_en_q)
		else $error("global enable still set after vector");
	a_vector_fixed: assert property (@(posedge clock) disable iff (sys_rst)
		vector_load |-> vector_addr == 13'h0004 && push_return)
		else $error("wrong vector or missing push");
	a_latency_exact: assert property (@(posedge clock) disable iff (sys_rst)
		vector_load |-> $past(wait_clks_q) == 5'(LATENCY_CLKS - 1))
		else $error("take latency not three instruction cycles");
	a_start_at_q1: assert property (@(posedge clock) disable iff (sys_rst)
		$rose(counting) |-> $past(phase_q) == Q1_PHASE)
		else $error("take sequence started outside q1");
	a_suppress_take: assert property (@(posedge clock) disable iff (sys_rst)
		counting && !glb_en_q |=> !vector_load ##1 !vector_load)
		else $error("vector taken after global enable cleared");
	a_return_sets_en: assert property (@(posedge clock) disable iff (sys_rst)
		return_from_isr |=> glb_en_q)
		else $error("return did not set global enable");
	a_ext_flag_set: assert property (@(posedge clock) disable iff (sys_rst)
		ext_edge |=> core_flags_q[BIT_EXT_FLAG])
		else $error("ext edge lost");
	a_periph_group: assert property (@(posedge clock) disable iff (sys_rst)
		!grp_en_q && !(|(core_flags_q & src_en_q)) |-> !pending_any)
		else $error("peripheral request passed closed group enable");
	a_analog_silent: assert property (@(posedge clock) disable iff (sys_rst)
		analog_q |-> !ext_edge && !pin_level)
		else $error("analog pin produced level or edge");
	a_wake_armed: assert property (@(posedge clock) disable iff (sys_rst)
		wake_up |-> wake_arm_q && core_flags_q[BIT_EXT_FLAG])
		else $error("wake without armed ext enable");
endmodule : mcu_interrupt_control
`default_nettype wire

//--- design/pin_edge_detect.sv
// Purpose: synchronise the external interrupt pin and find its active edge
// Assumes: pin is asynchronous to clock
// Notes: analog mode masks both the level and the edge
`timescale 1ns/1ps
`default_nettype none
module pin_edge_detect (
	// clock and reset
	input wire logic clock,
	input wire logic sys_rst,
	// pin and configuration
	input wire logic pin_raw,
	input wire logic polarity,
	input wire logic analog_sel,
	// results
	output logic pin_level,
	output logic edge_seen
);
	logic s1_q, s2_q, s3_q;
	logic s1_d, s2_d, s3_d;

	always_comb begin
		s1_d = pin_raw;
		s2_d = s1_q;
		s3_d = s2_q;
	end

	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			s1_q <= 1'b0;
			s2_q <= 1'b0;
			s3_q <= 1'b0;
		end else begin
			s1_q <= s1_d;
			s2_q <= s2_d;
			s3_q <= s3_d;
		end
	end

	// analog pin reads zero and never interrupts
	assign pin_level = s2_q & ~analog_sel;
	// edge taken from the raw synced pair so leaving analog mode cannot fake an edge
	assign edge_seen = ~analog_sel & (polarity ? (s2_q & ~s3_q) : (~s2_q & s3_q));
endmodule : pin_edge_detect
`default_nettype wire

//--- dv/core_model.sv
// Purpose: behavioural processor core facing the interrupt block
// Assumes: return and sleep are commanded by the bench as levels
// Notes: counts vector loads and marks any with a bad vector
`timescale 1ns/1ps
`default_nettype none
module core_model (
	// clock and reset
	input wire logic clock,
	input wire logic sys_rst,
	// from interrupt block
	input wire logic vector_load,
	input wire logic push_return,
	input wire logic [12:0] vector_addr,
	// bench commands
	input wire logic do_return,
	input wire logic do_sleep,
	// to interrupt block
	output logic return_from_isr,
	output logic sleep_active,
	// observation
	output int takes,
	output int bad_takes
);
	logic ret_q;
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			ret_q <= 1'b0;
			return_from_isr <= 1'b0;
			sleep_active <= 1'b0;
			takes <= 0;
			bad_takes <= 0;
		end else begin
			ret_q <= do_return;
			// one-cycle pulse per command, as a real return would give
			return_from_isr <= do_return & ~ret_q;
			sleep_active <= do_sleep;
			if (vector_load === 1'b1) begin
				takes <= takes + 1;
				if (push_return !== 1'b1 || vector_addr !== 13'h0004) begin
					bad_takes <= bad_takes + 1;
				end
			end
		end
	end
endmodule : core_model
`default_nettype wire

//--- dv/tb.sv
// Purpose: self-checking bench of the interrupt control block
// Assumes: zero-wait apb slave, phase counter reset to q4
// Notes: firmware behaviour is played by the bench tasks
`timescale 1ns/1ps
`default_nettype none
module tb;
	import irq_ctrl_pkg::*;
	logic clock = 1'b0;
	logic sys_rst = 1'b1;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata, rdat;
	logic pready, pslverr, rerr;
	logic ext_irq_pin = 1'b0, pin_change_irq = 1'b0, timer0_overflow = 1'b0;
	logic [N_PERIPH-1:0] periph_event = '0;
	logic return_from_isr, sleep_active, irq_request, vector_load, push_return, wake_up;
	logic do_return = 1'b0, do_sleep = 1'b0;
	logic [12:0] vector_addr;
	int takes, bad_takes, n;
	int err_count = 0;
	int n_compared = 0;
	logic [4:0] tbl [5] = '{5'b10011, 5'b10100, 5'b00101, 5'b00010, 5'b11010};

	mcu_interrupt_control dut_u (.clock(clock), .sys_rst(sys_rst), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .ext_irq_pin(ext_irq_pin),
		.pin_change_irq(pin_change_irq), .timer0_overflow(timer0_overflow),
		.periph_event(periph_event), .return_from_isr(return_from_isr),
		.sleep_active(sleep_active), .irq_request(irq_request), .vector_load(vector_load),
		.push_return(push_return), .vector_addr(vector_addr), .wake_up(wake_up));
	core_model core_u (.clock(clock), .sys_rst(sys_rst), .vector_load(vector_load),
		.push_return(push_return), .vector_addr(vector_addr), .do_return(do_return),
		.do_sleep(do_sleep), .return_from_isr(return_from_isr),
		.sleep_active(sleep_active), .takes(takes), .bad_takes(bad_takes));

	initial begin
		forever #25 clock = ~clock;
	end
	// ****************************************
	// shared tasks
	// ****************************************
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			err_count++;
			$display("unexpected %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int i;
		i = 0;
		@(posedge clock);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= {24'h0, a};
		pwdata <= d;
		@(posedge clock);
		penable <= 1'b1;
		// look at the answer while it is settled, before the edge that ends the access
		@(negedge clock);
		while (pready !== 1'b1 && i < 20) begin
			@(negedge clock);
			i++;
		end
		if (pready !== 1'b1) err_count++;
		rdat = prdata;
		rerr = pslverr;
		@(posedge clock);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask : wr
	task automatic rchk(input logic [7:0] a, input logic [31:0] e, input string nm);
		apb(1'b0, a, 32'h0);
		chk(nm, rdat, e);
	endtask : rchk
	task automatic evt(input logic [N_PERIPH+1:0] v);
		@(posedge clock);
		{periph_event, timer0_overflow, pin_change_irq} <= v;
		@(posedge clock);
		{periph_event, timer0_overflow, pin_change_irq} <= '0;
	endtask : evt
	// counts edges from the first sampled request to the sampled vector pulse
	task automatic wait_vec();
		n = 0;
		@(negedge clock);
		for (int i = 0; i < 40 && irq_request !== 1'b1; i++) @(negedge clock);
		do begin
			@(negedge clock);
			n++;
		end while (vector_load !== 1'b1 && n < 40);
		chk("latency", 32'(n >= LATENCY_CLKS + 1 && n <= LATENCY_CLKS + CLKS_PER_INSTR), 32'h1);
		// core model counts the pulse at the edge that ends it
		@(negedge clock);
	endtask : wait_vec
	// ****************************************
	// scenarios
	// ****************************************
	task automatic t_reset();
		rchk(OFS_CTRL, {24'h0, CTRL_RESET}, "ctrl reset");
		rchk(OFS_OPTION, 32'h1, "option reset");
		rchk(OFS_ANALOG, 32'h1, "analog sel reset");
		rchk(OFS_PEN, 32'h0, "pen reset");
		rchk(8'h18, 32'h0, "unmapped read");
		chk("unmapped err", {31'h0, rerr}, 32'h1);
		wr(OFS_CTRL, 32'h7f);
		rchk(OFS_CTRL, 32'h7f, "ctrl rw");
		chk("no global en", {31'h0, irq_request}, 32'h0);
		wr(OFS_CTRL, 32'h80);
		sys_rst <= 1'b1;
		repeat (2) @(posedge clock);
		sys_rst <= 1'b0;
		rchk(OFS_CTRL, 32'h0, "ctrl after reset");
	endtask : t_reset
	task automatic t_take();
		evt('h3);
		rchk(OFS_CTRL, 32'h05, "flags unmasked");
		wr(OFS_CTRL, 32'ha0);
		evt('h2);
		wait_vec();
		chk("takes", takes, 1);
		rchk(OFS_CTRL, 32'h24, "global en cleared");
		wr(OFS_CTRL, 32'h2c);
		evt('h1);
		repeat (20) @(posedge clock);
		chk("no take in isr", takes, 1);
		rchk(OFS_CTRL, 32'h2d, "flag in isr");
		do_return <= 1'b1;
		wait_vec();
		do_return <= 1'b0;
		chk("repeat take", takes, 2);
		wr(OFS_CTRL, 32'h0);
	endtask : t_take
	task automatic t_periph();
		for (int i = 0; i < N_PERIPH; i++) begin
			wr(OFS_PEN, 32'(1) << i);
			wr(OFS_CTRL, 32'h80);
			evt(14'(1) << (i + 2));
			// earlier sources stay flagged, nothing clears them in this loop
			rchk(OFS_PREQ, (32'(1) << (i + 1)) - 32'(1), "preq");
			chk("no group", {31'h0, irq_request}, 32'h0);
			wr(OFS_CTRL, 32'hc0);
			@(negedge clock);
			chk("group req", {31'h0, irq_request}, 32'h1);
			wr(OFS_CTRL, 32'h40);
		end
		repeat (20) @(posedge clock);
		chk("suppressed", takes, 2);
		apb(1'b0, OFS_STATUS, 32'h0);
		chk("status pending", {30'h0, rdat[BIT_ST_COUNTING:BIT_ST_PENDING]}, 32'h1);
		wr(OFS_CTRL, 32'hc0);
		wait_vec();
		chk("pending taken", takes, 3);
		wr(OFS_CTRL, 32'h0);
		wr(OFS_PREQ, 32'h0);
	endtask : t_periph
	task automatic t_ext();
		foreach (tbl[k]) begin
			wr(OFS_OPTION, {31'h0, tbl[k][4]});
			wr(OFS_ANALOG, {31'h0, tbl[k][3]});
			ext_irq_pin <= tbl[k][2];
			repeat (6) @(posedge clock);
			wr(OFS_CTRL, 32'h0);
			ext_irq_pin <= tbl[k][1];
			repeat (6) @(posedge clock);
			rchk(OFS_CTRL, {30'h0, tbl[k][0], 1'b0}, "ext flag");
			apb(1'b0, OFS_STATUS, 32'h0);
			chk("pin level", {31'h0, rdat[BIT_ST_PIN]}, {31'h0, tbl[k][1] & ~tbl[k][3]});
		end
		wr(OFS_CTRL, 32'h82);
		@(negedge clock);
		chk("ext masked", {31'h0, irq_request}, 32'h0);
		wr(OFS_CTRL, 32'h0);
	endtask : t_ext
	task automatic t_sleep();
		// pin back to idle while still masked, then give it to the digital side
		ext_irq_pin <= 1'b0;
		wr(OFS_ANALOG, 32'h0);
		wr(OFS_OPTION, 32'h1);
		wr(OFS_CTRL, 32'h10);
		do_sleep <= 1'b1;
		repeat (4) @(posedge clock);
		ext_irq_pin <= 1'b1;
		repeat (8) @(posedge clock);
		chk("wake armed", {31'h0, wake_up}, 32'h1);
		chk("no global req", {31'h0, irq_request}, 32'h0);
		apb(1'b0, OFS_STATUS, 32'h0);
		chk("wake arm", {31'h0, rdat[BIT_ST_WAKE_ARM]}, 32'h1);
		do_sleep <= 1'b0;
		ext_irq_pin <= 1'b0;
		wr(OFS_CTRL, 32'h0);
		do_sleep <= 1'b1;
		repeat (4) @(posedge clock);
		wr(OFS_CTRL, 32'h10);
		ext_irq_pin <= 1'b1;
		repeat (8) @(posedge clock);
		chk("wake unarmed", {31'h0, wake_up}, 32'h0);
		do_sleep <= 1'b0;
		chk("bad vectors", bad_takes, 0);
	endtask : t_sleep
	task automatic end_of_test();
		$display("compared %0d mismatches %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask : end_of_test
	// ****************************************
	// sequence and watchdog
	// ****************************************
	initial begin
		repeat (5) @(posedge clock);
		sys_rst <= 1'b0;
		t_reset();
		$display("test done: reset");
		t_take();
		$display("test done: take");
		t_periph();
		$display("test done: periph");
		t_ext();
		$display("test done: ext pin");
		t_sleep();
		$display("test done: sleep");
		end_of_test();
	end
	initial begin
		repeat (20000) @(posedge clock);
		err_count++;
		end_of_test();
	end
endmodule : tb
`default_nettype wire

//--- shared/irq_ctrl_pkg.sv
// Purpose: constants shared by the interrupt control block
// Assumes: 20 MHz clock, four clock phases per instruction cycle
// Notes: register offsets are byte addresses on a 32-bit APB bus
package irq_ctrl_pkg;
	// ****************************************
	// register map
	// ****************************************
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_PREQ = 8'h04;
	localparam logic [7:0] OFS_PEN = 8'h08;
	localparam logic [7:0] OFS_OPTION = 8'h0c;
	localparam logic [7:0] OFS_ANALOG = 8'h10;
	localparam logic [7:0] OFS_STATUS = 8'h14;
	// ****************************************
	// control register fields
	// ****************************************
	localparam int BIT_GLB_EN = 7;
	localparam int BIT_GRP_EN = 6;
	localparam int BIT_T0_EN = 5;
	localparam int BIT_EXT_EN = 4;
	localparam int BIT_PCH_EN = 3;
	localparam int BIT_T0_FLAG = 2;
	localparam int BIT_EXT_FLAG = 1;
	localparam int BIT_PCH_FLAG = 0;
	localparam logic [7:0] CTRL_RESET = 8'h00;
	// option register: bit 0 edge polarity; analog select: bit 0 ext pin
	localparam int BIT_POLARITY = 0;
	localparam int BIT_EXT_ANALOG = 0;
	localparam logic OPTION_RESET = 1'h1;
	localparam logic ANALOG_RESET = 1'h1;
	// status register fields
	localparam int BIT_ST_PENDING = 0;
	localparam int BIT_ST_COUNTING = 1;
	localparam int BIT_ST_PIN = 2;
	localparam int BIT_ST_WAKE_ARM = 3;
	// ****************************************
	// peripheral sources, order of request and enable bits
	// ****************************************
	localparam int N_PERIPH = 12;
	localparam logic [N_PERIPH-1:0] PERIPH_RESET = 12'h000;
	// 0 timer1, 1 timer2, 2 adc, 3 input uv, 4 input ov, 5 serial,
	// 6 bus collision, 7 desat, 8 gate drive uv, 9 cc1, 10 cc2, 11 overtemp
	// ****************************************
	// timing
	// ****************************************
	localparam int CLK_PERIOD_NS = 50;
	localparam int INSTR_CYCLE_NS = 200;
	localparam int CLKS_PER_INSTR = INSTR_CYCLE_NS / CLK_PERIOD_NS;
	localparam logic [1:0] Q1_PHASE = 2'h0;
	localparam logic [1:0] Q4_PHASE = 2'h3;
	localparam logic [1:0] LATENCY_INSTR = 2'h3;
	localparam int LATENCY_CLKS = 3 * CLKS_PER_INSTR;
	localparam logic [12:0] VECTOR_ADDR = 13'h0004;
	typedef enum logic [0:0] {ST_IDLE, ST_COUNT} take_state_e;
endpackage : irq_ctrl_pkg
